// ### rtl/ord_defines.svh
// Offsets, field positions, reset values and timing counts for the orientation block.
// Assumes a 125 MHz pclk and register indices scaled by four onto APB byte addresses.
`ifndef ORD_DEFINES_SVH
`define ORD_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ORD_IDX_DEVICE_IDENTITY    8'h0D
`define ORD_IDX_RANGE_CONFIG       8'h0E
`define ORD_IDX_ORIENT_STATUS      8'h10
`define ORD_IDX_ORIENT_CONFIG      8'h11
`define ORD_IDX_ORIENT_DEBOUNCE    8'h12
`define ORD_IDX_ORIENT_IRQ_CTRL    8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ORD_STAT_CHANGE_BIT        7
`define ORD_STAT_LOCKOUT_BIT       6
`define ORD_STAT_CODE_HI           2
`define ORD_STAT_CODE_LO           1
`define ORD_STAT_BACK_FRONT_BIT    0
`define ORD_CFG_DEBOUNCE_MODE_BIT  7
`define ORD_CFG_ENABLE_BIT         6
`define ORD_IRQ_ENABLE_BIT         0
`define ORD_IRQ_SOURCE_BIT         4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ORD_RST_RANGE              2'h0
`define ORD_RST_DEBOUNCE_MODE      1'b1
`define ORD_RST_ENABLE             1'b0
`define ORD_RST_DEBOUNCE_COUNT     8'h00
`define ORD_RST_ORIENT_CODE        2'h0

// ----------------------------------------------------------------
// Timing and thresholds
// ----------------------------------------------------------------
`define ORD_CLK_PERIOD_PS          8000
`define ORD_STEP_BASE_US           1250
`define ORD_STEP_BASE_CYC          ((`ORD_STEP_BASE_US * 1000000) / `ORD_CLK_PERIOD_PS)
// Acceleration in counts of 1/1024 g; lock limit is 1.25 g
`define ORD_LOCK_LIMIT             16'h0500

`endif

// ### rtl/ord_pkg.sv
// Types shared by the orientation detect and range configuration block.
// Assumes ord_defines.svh supplies the register, field and timing numbers.
package ord_pkg;

  typedef enum logic [1:0] {
    ORD_RANGE_2G  = 2'h0,
    ORD_RANGE_4G  = 2'h1,
    ORD_RANGE_8G  = 2'h2,
    ORD_RANGE_RSV = 2'h3
  } ord_range_t;

  typedef enum logic [1:0] {
    ORD_PORTRAIT_UP   = 2'h0,
    ORD_PORTRAIT_DOWN = 2'h1,
    ORD_LAND_RIGHT    = 2'h2,
    ORD_LAND_LEFT     = 2'h3
  } ord_code_t;

  typedef enum logic [1:0] {
    ORD_OS_NORMAL  = 2'h0,
    ORD_OS_LOW_NOISE_LOW_POWER    = 2'h1,
    ORD_OS_HIRES   = 2'h2,
    ORD_OS_LOWPWR  = 2'h3
  } ord_os_t;

  // Rate select: 0=800, 1=400, 2=200, 3=100, 4=50, 5=12.5, 6=6.25, 7=1.56 Hz
  typedef logic [2:0] ord_odr_t;

  typedef struct packed {
    logic      tilt_lockout;
    ord_code_t orient_code;
    logic      back_front;
  } ord_orient_t;

endpackage : ord_pkg

// ### rtl/ord_orientation_regs.sv
// Orientation detector, range select and identity registers behind an APB slave.
// Assumes accel samples, rate, oversample mode and power state come from logic on pclk.
// Assumes the host reads status to clear the change flag and its interrupt.
// Assumes TICK_BASE_CYCLES clocks make one 1.25 ms base step.
//
// Notes on behaviour
// RULE_01: two-bit range field: 00 2 g, 01 4 g, 10 8 g, 11 reserved.
// RULE_02: range field resets to the 2 g setting.
// RULE_03: change flag sets on first detection after activation and on any field change.
// RULE_04: any status read clears the change flag and the interrupt source; here only a read that returned the flag set clears them.
// RULE_05: lockout bit set when tilt trip angle exceeded, else zero.
// RULE_06: orientation code: 0 up, 1 down, 2 landscape right, 3 landscape left.
// RULE_07: back/front bit is 0 for front, 1 for back.
// RULE_08: back/front, orientation code and lockout are zero at reset.
// RULE_09: no state change while any axis magnitude exceeds 1.25 g.
// RULE_10: status fields keep updating while the change flag is set.
// RULE_11: debounce mode 0 decrements, 1 clears counter on invalid condition; default 1.
// RULE_12: enable bit turns detection on; default off.
// RULE_13: eight-bit debounce count, default zero, steps needed before a transition.
// RULE_14: every wake/sleep change resets the debounce counter.
// RULE_15: step is one sample period in normal, low-noise and low-power modes.
// RULE_16: high-resolution step is 1.25 ms at 800 Hz, else 2.5 ms.
// RULE_17: slow rates: normal 20 ms, low-noise 80 ms, low-power 80 or 160 ms.
// RULE_18: fixed eight-bit identity code readable at index 0x0D.
// RULE_19: reserved bits read zero; writes to read-only registers do nothing.
// RULE_20: disabled detector holds status and flag and raises no interrupt.
// RULE_21: interrupt source follows flag when enabled; cleared by status read.
`timescale 1ns/1ps
`include "ord_defines.svh"

module ord_orientation_regs
  import ord_pkg::*;
#(
  parameter logic [7:0]  IDENTITY_CODE    = 8'hA5,  // Arbitrary value
  parameter int unsigned TICK_BASE_CYCLES = `ORD_STEP_BASE_CYC
) (
  input  wire  logic              pclk,
  input  wire  logic              presetn,
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [31:0]       paddr,
  input  wire  logic [31:0]       pwdata,
  output logic       [31:0]       prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire  logic              sample_valid,
  input  wire  logic signed [15:0] accel_x,
  input  wire  logic signed [15:0] accel_y,
  input  wire  logic signed [15:0] accel_z,
  input  wire  ord_orient_t       orient_candidate,
  input  wire  ord_odr_t          odr_sel,
  input  wire  ord_os_t           os_mode,
  input  wire  logic              active_mode,
  input  wire  logic              sleep_state,
  output ord_range_t              range_sel,
  output ord_orient_t             orient_now,
  output logic                    orient_change_flag,
  output logic                    orient_irq_source
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic over_limit(input logic signed [15:0] a);
    logic [15:0] mag;
    mag = a[15] ? 16'(-a) : 16'(a);
    // Strictly greater: exactly 1.25 g still allows a change
    return mag > `ORD_LOCK_LIMIT;
  endfunction : over_limit

  // Step length in multiples of 1.25 ms
  function automatic logic [7:0] step_mult(input ord_odr_t odr, input ord_os_t os);
    logic [7:0] m;
    unique case (odr)
      3'h0:    m = 8'h01;
      3'h1:    m = 8'h02;
      3'h2:    m = 8'h04;
      3'h3:    m = 8'h08;
      3'h4:    m = 8'h10;
      3'h5:    m = (os == ORD_OS_NORMAL) ? 8'h10 : 8'h40;
      default: m = (os == ORD_OS_NORMAL) ? 8'h10 : (os == ORD_OS_LOW_NOISE_LOW_POWER) ? 8'h40 : 8'h80;
    endcase
    // High resolution fixes 2.5 ms below 800 Hz
    if (os == ORD_OS_HIRES && odr != 3'h0) begin
      m = 8'h02;
    end
    return m;
  endfunction : step_mult

  function automatic logic idx_hit(input logic [31:0] a, input logic [7:0] idx);
    return a == {22'h000000, idx, 2'h0};
  endfunction : idx_hit

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        debounce_mode;
  logic        orient_enable;
  logic [7:0]  debounce_count;
  logic        irq_enable;
  logic        cap_change;
  logic        setup_phase;
  logic        wr_done;
  logic        rd_status_done;
  logic        mapped;
  logic [7:0]  next_rdata;
  logic        wr_range;
  logic        wr_config;
  logic        wr_debounce;
  logic        wr_irq_ctrl;
  logic        status_clear;

  assign setup_phase    = psel & ~penable;
  assign wr_done        = psel & penable & pready & pwrite;
  assign rd_status_done = psel & penable & pready & ~pwrite & idx_hit(paddr, `ORD_IDX_ORIENT_STATUS);

  assign wr_range       = wr_done & idx_hit(paddr, `ORD_IDX_RANGE_CONFIG);
  assign wr_config      = wr_done & idx_hit(paddr, `ORD_IDX_ORIENT_CONFIG);
  assign wr_debounce    = wr_done & idx_hit(paddr, `ORD_IDX_ORIENT_DEBOUNCE);
  assign wr_irq_ctrl    = wr_done & idx_hit(paddr, `ORD_IDX_ORIENT_IRQ_CTRL);
  // Clear only a flag the read really returned
  assign status_clear   = rd_status_done & cap_change;

  always_comb begin
    mapped     = 1'b1;
    next_rdata = 8'h00;
    // RULE_19: reserved bits zero
    if (idx_hit(paddr, `ORD_IDX_DEVICE_IDENTITY)) begin
      // RULE_18: identity readout
      next_rdata = IDENTITY_CODE;
    end else if (idx_hit(paddr, `ORD_IDX_RANGE_CONFIG)) begin
      next_rdata = {6'h00, range_sel};
    end else if (idx_hit(paddr, `ORD_IDX_ORIENT_STATUS)) begin
      next_rdata = {orient_change_flag, orient_now.tilt_lockout, 3'h0,
                    orient_now.orient_code, orient_now.back_front};
    end else if (idx_hit(paddr, `ORD_IDX_ORIENT_CONFIG)) begin
      next_rdata = {debounce_mode, orient_enable, 6'h00};
    end else if (idx_hit(paddr, `ORD_IDX_ORIENT_DEBOUNCE)) begin
      next_rdata = debounce_count;
    end else if (idx_hit(paddr, `ORD_IDX_ORIENT_IRQ_CTRL)) begin
      next_rdata = {3'h0, orient_irq_source, 3'h0, irq_enable};
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: data is sampled in setup so prdata comes from a flop
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      // Zero wait states: every access answers at once
      pready <= setup_phase;
      if (setup_phase) begin
        pslverr <= ~mapped;
        prdata  <= pwrite ? 32'h00000000 : {24'h000000, next_rdata};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Remembers whether the captured read actually showed the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_change <= 1'b0;
    end else if (setup_phase) begin
      cap_change <= orient_change_flag;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE_02: 2 g after reset
      range_sel <= ORD_RANGE_2G;
    end else if (wr_range) begin
      // Reserved code 11 is kept as written
      // RULE_01: range field store
      range_sel <= ord_range_t'(pwdata[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE_11: clear mode default
      debounce_mode <= `ORD_RST_DEBOUNCE_MODE;
      // RULE_12: disabled by default
      orient_enable <= `ORD_RST_ENABLE;
    end else if (wr_config) begin
      debounce_mode <= pwdata[`ORD_CFG_DEBOUNCE_MODE_BIT];
      orient_enable <= pwdata[`ORD_CFG_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE_13: count resets to zero
      debounce_count <= `ORD_RST_DEBOUNCE_COUNT;
    end else if (wr_debounce) begin
      debounce_count <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= 1'b0;
    end else if (wr_irq_ctrl) begin
      irq_enable <= pwdata[`ORD_IRQ_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Debounce time base
  // ----------------------------------------------------------------
  logic        sleep_q;
  logic        active_q;
  logic        power_change;
  logic [25:0] step_cycles;
  logic [25:0] tick_cnt;
  logic        step_tick;

  // Either direction of the sleep change counts
  assign power_change = sleep_state ^ sleep_q;
  // RULE_15: one sample period per step
  // RULE_16: high-resolution steps
  // RULE_17: slow-rate steps
  assign step_cycles  = 26'(TICK_BASE_CYCLES * int'(step_mult(odr_sel, os_mode)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Awake and standby are the levels after power-up
      sleep_q  <= 1'b0;
      active_q <= 1'b0;
    end else begin
      sleep_q  <= sleep_state;
      active_q <= active_mode;
    end
  end

  // Timer restarts on power state change so a partial step is not counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt  <= 26'h0000000;
      step_tick <= 1'b0;
    // Wrap at length minus one: one tick per step_cycles clocks
    end else if (power_change || !active_mode || tick_cnt >= step_cycles - 26'h0000001) begin
      tick_cnt  <= 26'h0000000;
      step_tick <= active_mode & ~power_change;
    end else begin
      tick_cnt  <= tick_cnt + 26'h0000001;
      step_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Candidate latch and detection condition
  // ----------------------------------------------------------------
  ord_orient_t cand_q;
  logic        locked;
  logic        first_pending;
  logic        cond_valid;
  logic [7:0]  db_cnt;
  logic        accept;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_q <= '0;
      locked <= 1'b0;
    end else if (sample_valid) begin
      cand_q <= orient_candidate;
      // RULE_09: lock above 1.25 g on any axis
      locked <= over_limit(accel_x) | over_limit(accel_y) | over_limit(accel_z);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pending <= 1'b0;
    end else if (active_mode && !active_q) begin
      first_pending <= 1'b1;
    // Standby drops a report still pending
    end else if (accept || !active_mode) begin
      first_pending <= 1'b0;
    end
  end

  // Lock verdict holds until the next sample arrives
  // RULE_09: no change while locked
  // RULE_20: disabled detector holds state
  assign cond_valid = orient_enable & ~locked & (first_pending | (cand_q != orient_now));
  assign accept     = step_tick & cond_valid & (db_cnt >= debounce_count);

  // ----------------------------------------------------------------
  // Debounce counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_cnt <= 8'h00;
    end else if (power_change) begin
      // RULE_14: wake/sleep resets counter
      db_cnt <= 8'h00;
    end else if (step_tick) begin
      if (accept) begin
        db_cnt <= 8'h00;
      end else if (cond_valid) begin
        // Saturates so a long valid run never wraps to zero
        // RULE_13: count steps toward threshold
        db_cnt <= (db_cnt == 8'hFF) ? db_cnt : db_cnt + 8'h01;
      end else if (debounce_mode) begin
        // RULE_11: clear mode
        db_cnt <= 8'h00;
      end else if (db_cnt != 8'h00) begin
        // RULE_11: decrement mode
        db_cnt <= db_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status fields and change flag
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE_08: zero at power-up
      orient_now <= '0;
    end else if (accept) begin
      // RULE_05: lockout
      // RULE_06: orientation code
      // RULE_07: back/front
      // RULE_10: updates regardless of flag
      orient_now <= cand_q;
    end
  end

  // Only clear a flag the read really returned; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      orient_change_flag <= 1'b0;
    end else if (accept) begin
      // RULE_03: set on first detection or change
      orient_change_flag <= 1'b1;
    end else if (status_clear) begin
      // RULE_04: cleared by status read
      orient_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      orient_irq_source <= 1'b0;
    end else if (accept && irq_enable) begin
      // RULE_21: source follows flag
      // RULE_20: no interrupt while disabled
      orient_irq_source <= 1'b1;
    end else if (status_clear || !irq_enable) begin
      // RULE_04: read clears interrupt
      orient_irq_source <= 1'b0;
    end else if (orient_enable && irq_enable && orient_change_flag) begin
      // RULE_21: enable after flag
      orient_irq_source <= 1'b1;
    end
  end

endmodule : ord_orientation_regs

// ### testbench/ord_apb_host.sv
// Host model: APB master moving one register word per call.
// Assumes a free-running pclk and a slave that raises pready.
`timescale 1ns/1ps

module ord_apb_host (
  input  wire logic        pclk,
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic      [31:0] paddr   = 32'h0,
  output logic      [31:0] pwdata  = 32'h0,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Byte address is four times the index
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines carry junk, not the last value
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : ord_apb_host

// ### testbench/ord_orientation_asserts.sv
// Port-level checker for the orientation register block.
// Assumes one pclk domain and asynchronous active-low presetn.
`timescale 1ns/1ps

module ord_orientation_checker
  import ord_pkg::*;
#(
  parameter int unsigned TICK_BASE_CYCLES = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire ord_range_t  range_sel,
  input wire ord_orient_t orient_now,
  input wire logic        orient_change_flag,
  input wire logic        orient_irq_source
);
  logic       acc;
  logic       rd_stat;
  logic       wr_range;
  logic [1:0] wd_lo;
  logic [7:0] stat_img;
  assign acc      = psel && penable && pready;
  assign rd_stat  = acc && !pwrite && (paddr == 32'h40);
  assign wr_range = acc && pwrite && (paddr == 32'h38) && !pslverr;
  assign wd_lo    = pwdata[1:0];
  assign stat_img = {orient_change_flag, orient_now.tilt_lockout, 3'h0, orient_now.orient_code,
                     orient_now.back_front};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("No ready in access cycle");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("Upper read bits not zero");
  err_data_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("Refused access returned data");
  range_write_a: assert property (wr_range |=> range_sel == $past(wd_lo))
    else $error("Range field not written");
  range_hold_a: assert property ($changed(range_sel) |-> $past(wr_range))
    else $error("Range field changed without write");
  flag_on_change_a: assert property ($changed(orient_now) |-> orient_change_flag)
    else $error("Status change without flag");
  read_clears_a: assert property (rd_stat && prdata[7] |=> !orient_change_flag || $changed(orient_now))
    else $error("Status read left flag set");
  irq_needs_flag_a: assert property (orient_irq_source |-> orient_change_flag)
    else $error("Interrupt source without flag");
  status_data_a: assert property (rd_stat |-> prdata[7:0] == $past(stat_img))
    else $error("Status read data wrong");

  cover_clear_c: cover property (rd_stat && orient_change_flag);
  cover_irq_c: cover property ($rose(orient_irq_source));
  cover_err_c: cover property (pready && pslverr);
endmodule : ord_orientation_checker

bind ord_orientation_regs ord_orientation_checker #(.TICK_BASE_CYCLES(TICK_BASE_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .range_sel(range_sel), .orient_now(orient_now), .orient_change_flag(orient_change_flag),
  .orient_irq_source(orient_irq_source));

// ### testbench/ord_orientation_regs_tb.sv
// Bench: registers over APB, detector fed through the sample port.
// Assumes ord_apb_host as bus master and a short debounce tick base.
`timescale 1ns/1ps

module ord_orientation_regs_tb
  import ord_pkg::*;
;
  localparam logic [7:0]  IDC   = 8'h3C;  // Arbitrary identity value
  localparam int unsigned TICKS = 4;
  logic               pclk, psel, penable, pwrite, pready, pslverr, err;
  logic               presetn = 1'b0, sample_valid = 1'b0, active_mode = 1'b1, sleep_state = 1'b0;
  logic [31:0]        paddr, pwdata, prdata, rd;
  logic signed [15:0] accel_x = 16'sh0, accel_y = 16'sh0, accel_z = 16'sh0;
  ord_orient_t        cand = 4'h0, orient_now;
  ord_odr_t           odr_sel = 3'h0;
  ord_os_t            os_mode = ORD_OS_NORMAL;
  ord_range_t         range_sel;
  logic               orient_change_flag, orient_irq_source;
  int                 n_mismatch = 0, checks_done = 0, cyc = 0;

  ord_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ord_orientation_regs #(.IDENTITY_CODE(IDC), .TICK_BASE_CYCLES(TICKS)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .orient_candidate(cand), .odr_sel(odr_sel), .os_mode(os_mode), .active_mode(active_mode),
    .sleep_state(sleep_state), .range_sel(range_sel), .orient_now(orient_now),
    .orient_change_flag(orient_change_flag), .orient_irq_source(orient_irq_source));

  initial begin
    pclk = 1'b0;
    forever
      #4 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  // Hang guard: whole run needs a few thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared drivers and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host.xfer(1'b1, i, d, rd, err);
  endtask : wr

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    host.xfer(1'b0, i, 8'h00, rd, err);
    chk(rd, {24'h0, e});
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic feed(input ord_orient_t c, input logic signed [15:0] ax);
    @(posedge pclk);
    sample_valid <= 1'b1;
    cand <= c;
    accel_x <= ax;
    @(posedge pclk);
    sample_valid <= 1'b0;
  endtask : feed

  task automatic wflag(input int lim, output int n);
    n = 0;
    while (orient_change_flag !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wflag

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc(8'h0D, IDC);
    rdc(8'h0E, 8'h00);
    rdc(8'h10, 8'h00);
    rdc(8'h11, 8'h80);
    rdc(8'h12, 8'h00);
    host.xfer(1'b0, 8'h0F, 8'h00, rd, err);
    chk({err, rd[30:0]}, 32'h80000000);
    wr(8'h0D, 8'hFF);
    rdc(8'h0D, IDC);
    wr(8'h10, 8'hFF);
    rdc(8'h10, 8'h00);
  endtask : t_reset

  task automatic t_range;
    for (int i = 0; i < 4; i++) begin
      wr(8'h0E, 8'hFC | i[7:0]);
      rdc(8'h0E, i[7:0]);
      @(negedge pclk);
      chk({30'h0, range_sel}, i);
    end
  endtask : t_range

  task automatic t_detect;
    int n;
    wr(8'h20, 8'h01);
    // Candidate first: the pending first report must carry it
    feed(4'h5, 16'sh0000);
    wr(8'h11, 8'hC0);
    wflag(40, n);
    @(negedge pclk);
    chk({31'h0, orient_irq_source}, 32'h1);
    rdc(8'h10, 8'h85);
    @(negedge pclk);
    chk({31'h0, orient_irq_source}, 32'h0);
    rdc(8'h10, 8'h05);
    active_mode <= 1'b0;
    idle(8);
    active_mode <= 1'b1;
    wflag(40, n);
    rdc(8'h10, 8'h85);
  endtask : t_detect

  // Negative overload must hold; exactly 1.25 g must not
  task automatic t_lock;
    int n;
    feed(4'h2, 16'shFA00);
    idle(40);
    chk({27'h0, orient_change_flag, orient_now}, 32'h05);
    feed(4'h2, 16'sh0500);
    wflag(40, n);
    chk({28'h0, orient_now}, 32'h2);
    feed(4'hE, 16'sh0000);
    idle(40);
    chk({27'h0, orient_change_flag, orient_now}, 32'h1E);
    rdc(8'h10, 8'hC6);
    rdc(8'h10, 8'h46);
  endtask : t_lock

  task automatic t_disable;
    int n;
    wr(8'h11, 8'h80);
    feed(4'h0, 16'sh0000);
    idle(40);
    chk({26'h0, orient_irq_source, orient_change_flag, orient_now}, 32'h0E);
    wr(8'h11, 8'hC0);
    wflag(40, n);
    rdc(8'h10, 8'h80);
  endtask : t_disable

  // Cycles from sample to flag must fit count and tick weighting
  task automatic dbn(input ord_odr_t o, input ord_os_t m, input logic [7:0] c,
                     input ord_orient_t v, input logic sl, input int lo, input int hi);
    int n;
    odr_sel <= o;
    os_mode <= m;
    wr(8'h12, c);
    feed(v, 16'sh0000);
    if (sl) begin
      idle(8);
      sleep_state <= ~sleep_state;
    end
    wflag(2000, n);
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
    rdc(8'h10, {1'b1, v.tilt_lockout, 3'h0, v.orient_code, v.back_front});
  endtask : dbn

  // Decrement mode: one invalid step costs one count, not all
  task automatic t_decrement;
    int n;
    odr_sel <= 3'd0;
    os_mode <= ORD_OS_NORMAL;
    wr(8'h11, 8'h40);
    wr(8'h12, 8'h03);
    feed(4'h6, 16'sh0600);
    // Timer restart fixes the step phase
    sleep_state <= ~sleep_state;
    feed(4'h6, 16'sh0000);
    idle(12);
    feed(4'h6, 16'sh0600);
    feed(4'h6, 16'sh0000);
    wflag(40, n);
    chk({31'h0, n >= 7 && n <= 11}, 32'h1);
    rdc(8'h10, 8'h86);
  endtask : t_decrement

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_range();
    t_detect();
    t_lock();
    t_disable();
    dbn(3'd0, ORD_OS_NORMAL, 8'h03, 4'h1, 1'b0, 12, 20);
    dbn(3'd0, ORD_OS_NORMAL, 8'h03, 4'h3, 1'b1, 12, 20);
    dbn(3'd3, ORD_OS_HIRES, 8'h02, 4'h5, 1'b0, 16, 28);
    dbn(3'd2, ORD_OS_NORMAL, 8'h01, 4'h7, 1'b0, 16, 36);
    dbn(3'd5, ORD_OS_LOW_NOISE_LOW_POWER, 8'h01, 4'h9, 1'b0, 256, 516);
    dbn(3'd6, ORD_OS_LOWPWR, 8'h01, 4'h0, 1'b0, 512, 1028);
    t_decrement();
    stop_test();
  end
endmodule : ord_orientation_regs_tb
